// ==== scp_pkg.sv ====
// Shared constants and types of the serial port core
// Assumes a 32-bit APB master and one system clock.
package scp_pkg;

  // --------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------
  localparam int unsigned PADDR_W      = 8;
  localparam logic [7:0]  OFF_CONTROL  = 8'h00;
  localparam logic [7:0]  OFF_DATA     = 8'h04;
  localparam logic [7:0]  OFF_STATUS   = 8'h08;
  localparam logic [7:0]  OFF_MASK     = 8'h0c;
  localparam logic [7:0]  OFF_ADDR     = 8'h10;
  localparam logic [7:0]  OFF_AMASK    = 8'h14;
  localparam logic [7:0]  OFF_BAUD     = 8'h18;

  // Control register fields
  localparam int unsigned CTL_RX_DONE  = 0;
  localparam int unsigned CTL_TX_DONE  = 1;
  localparam int unsigned CTL_RX_NINTH = 2;
  localparam int unsigned CTL_TX_NINTH = 3;
  localparam int unsigned CTL_REN      = 4;
  localparam int unsigned CTL_MP       = 5;
  localparam int unsigned CTL_MODE_LO  = 6;
  localparam int unsigned CTL_MODE_HI  = 7;

  // Sticky status fields, same layout in the mask register
  localparam int unsigned ST_W         = 4;
  localparam int unsigned ST_RX_DONE   = 0;
  localparam int unsigned ST_TX_DONE   = 1;
  localparam int unsigned ST_OVERRUN   = 2;
  localparam int unsigned ST_FRAME     = 3;
  localparam int unsigned BAUD_SMOD    = 16;

  // Reset values
  localparam logic [7:0]  CONTROL_RST  = 8'h00;
  localparam logic [3:0]  MASK_RST     = 4'h0;
  localparam logic [7:0]  ADDR_RST     = 8'h00;
  localparam logic [7:0]  AMASK_RST    = 8'h00;
  localparam logic [15:0] RELOAD_RST   = 16'h0000;

  // Timing counts in 16x ticks (OS_*) and in system clock cycles
  localparam logic [3:0]  OS_LAST      = 4'hf;
  localparam logic [3:0]  OS_MID       = 4'h7;
  localparam logic [3:0]  M0_LAST      = 4'hb;
  localparam logic [3:0]  M0_HALF      = 4'h6;
  localparam logic [15:0] M2_FAST      = 16'h0001;
  localparam logic [15:0] M2_SLOW      = 16'h0003;

  typedef enum logic [1:0] {
    SCP_SYNC, SCP_ASYNC8, SCP_ASYNC9_FIXED, SCP_ASYNC9_VAR
  } scp_mode_type;

  typedef enum logic [2:0] {
    TX_IDLE, TX_START, TX_DATA, TX_NINTH, TX_STOP
  } scp_tx_state_type;

  typedef enum logic [1:0] {
    RX_IDLE, RX_START, RX_BITS, RX_STOP
  } scp_rx_state_type;

  function automatic logic scp_nine(input scp_mode_type m);
    return (m == SCP_ASYNC9_FIXED) || (m == SCP_ASYNC9_VAR);
  endfunction

endpackage

// ==== scp_rx.sv ====
// Asynchronous receive shifter with 16x oversampling
// Assumes a synchronised line level and a one-cycle 16x tick.
`timescale 1ns/1ps
module scp_rx (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       tick,
  input  wire logic       enable,
  input  wire logic       nine_bits,
  input  wire logic       line,
  output      logic       done,
  output      logic [7:0] data,
  output      logic       ninth,
  output      logic       stop_bit
);
  import scp_pkg::*;

  scp_rx_state_type state;
  logic [3:0]       os;
  logic [3:0]       bitcnt;
  logic [8:0]       sh;

  wire       at_mid   = tick & (os == OS_MID);
  wire       at_bit   = tick & (os == OS_LAST);
  wire [3:0] last_bit = nine_bits ? 4'h8 : 4'h7;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state    <= RX_IDLE;
      os       <= 4'h0;
      bitcnt   <= 4'h0;
      sh       <= 9'h000;
      done     <= 1'b0;
      data     <= 8'h00;
      ninth    <= 1'b0;
      stop_bit <= 1'b0;
    end else begin
      done <= 1'b0;
      if (tick) begin
        os <= os + 4'h1;
      end
      case (state)
        RX_IDLE: begin
          os <= 4'h0;
          if (enable && !line) begin
            state <= RX_START;
          end
        end
        RX_START: begin
          // Start bit must still be low at its middle
          if (at_mid) begin
            os     <= 4'h0;
            bitcnt <= 4'h0;
            state  <= line ? RX_IDLE : RX_BITS;
          end
        end
        RX_BITS: begin
          if (at_bit) begin
            sh     <= {line, sh[8:1]};
            bitcnt <= bitcnt + 4'h1;
            if (bitcnt == last_bit) begin
              state <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (at_bit) begin
            done     <= 1'b1;
            stop_bit <= line;
            data     <= nine_bits ? sh[7:0] : sh[8:1];
            ninth    <= nine_bits ? sh[8] : line;
            state    <= RX_IDLE;
          end
        end
        default: state <= RX_IDLE;
      endcase
    end
  end

endmodule

// ==== scp_core.sv ====
// Serial port core: APB registers, transmitter, receivers, interrupt
// Assumes an APB master on pclk and a remote node on the two pins.
// Contract
// - Supports full-duplex async, half-duplex sync and multiprocessor modes.
// - Receive path detects framing errors and recognises its own address.
// - Received bytes go to a holding buffer while the next shifts in.
// - Overrun flag sets when a new byte arrives before the last is read.
// - One data address: reads give received byte, writes load transmitter.
// - Transmit-done flag, control bit 1, sets when a byte has been sent.
// - Receive-done flag, control bit 0, sets when a byte has been received.
// - Flags never clear on interrupt entry; software clears them explicitly.
// - One interrupt request while an enabled done flag is set; the overrun and frame flags also raise it when enabled.
// - Sync mode: device makes shift clock at system clock over twelve.
// - Async 8-bit frame: start, eight data bits LSB first, one stop.
// - Byte loads only if receive-done clear and, if checking, stop is one (8-bit) or ninth bit is one and address matches (9-bit).
`timescale 1ns/1ps
module scp_core (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [scp_pkg::PADDR_W-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  output      logic [31:0]                 prdata,
  output      logic                        pready,
  output      logic                        pslverr,
  input  wire logic                        rx_pin_in,
  output      logic                        rx_pin_out,
  output      logic                        rx_pin_oe,
  output      logic                        tx_pin_out,
  output      logic                        irq
);
  import scp_pkg::*;

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  scp_mode_type     mode;
  logic             mp_en;
  logic             ren;
  logic             tb8;
  logic             rb8;
  logic [ST_W-1:0]  sticky;
  logic [ST_W-1:0]  irq_mask;
  logic [7:0]       own_addr;
  logic [7:0]       addr_mask;
  logic [15:0]      reload;
  logic             smod;
  logic [7:0]       rx_buf;
  logic             rx_unread;

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  wire setup     = psel & ~penable;
  wire access    = psel & penable;
  wire hit_ctl   = paddr == OFF_CONTROL;
  wire hit_data  = paddr == OFF_DATA;
  wire hit_stat  = paddr == OFF_STATUS;
  wire hit_mask  = paddr == OFF_MASK;
  wire hit_addr  = paddr == OFF_ADDR;
  wire hit_amask = paddr == OFF_AMASK;
  wire hit_baud  = paddr == OFF_BAUD;
  wire mapped    = hit_ctl | hit_data | hit_stat | hit_mask | hit_addr
                   | hit_amask | hit_baud;
  wire wr        = access & pwrite;
  wire rd        = access & ~pwrite;
  wire tx_kick   = wr & hit_data;
  wire ri        = sticky[ST_RX_DONE];
  wire ti        = sticky[ST_TX_DONE];
  wire nine      = scp_nine(mode);
  wire is_sync   = mode == SCP_SYNC;

  assign pready     = 1'b1;
  assign pslverr    = access & ~mapped;
  assign rx_pin_out = 1'b0;

  wire [7:0] ctl_view = {mode, mp_en, ren, tb8, rb8, ti, ri};
  wire [31:0] rd_value =
      hit_ctl   ? {24'h000000, ctl_view} :
      hit_data  ? {24'h000000, rx_buf} :
      hit_stat  ? {28'h0000000, sticky} :
      hit_mask  ? {28'h0000000, irq_mask} :
      hit_addr  ? {24'h000000, own_addr} :
      hit_amask ? {24'h000000, addr_mask} :
      hit_baud  ? {15'h0000, smod, reload} : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup && !pwrite) begin
      prdata <= rd_value;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode      <= scp_mode_type'(CONTROL_RST[CTL_MODE_HI:CTL_MODE_LO]);
      {mp_en, ren, tb8} <= CONTROL_RST[CTL_MP:CTL_TX_NINTH];
      irq_mask  <= MASK_RST;
      own_addr  <= ADDR_RST;
      addr_mask <= AMASK_RST;
      reload    <= RELOAD_RST;
      smod      <= 1'b0;
    end else if (wr) begin
      if (hit_ctl) begin
        mode  <= scp_mode_type'(pwdata[CTL_MODE_HI:CTL_MODE_LO]);
        mp_en <= pwdata[CTL_MP];
        ren   <= pwdata[CTL_REN];
        tb8   <= pwdata[CTL_TX_NINTH];
      end
      if (hit_mask) irq_mask <= pwdata[ST_W-1:0];
      if (hit_addr) own_addr <= pwdata[7:0];
      if (hit_amask) addr_mask <= pwdata[7:0];
      if (hit_baud) begin
        reload <= pwdata[15:0];
        smod   <= pwdata[BAUD_SMOD];
      end
    end
  end

  // ------------------------------------------------------------
  // Baud tick: 16x oversampling rate
  // ------------------------------------------------------------
  logic [15:0] baud_cnt;
  wire  [15:0] baud_top = (mode == SCP_ASYNC9_FIXED) ? (smod ? M2_FAST : M2_SLOW)
                                                      : reload;
  wire         tick16   = baud_cnt == baud_top;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) baud_cnt <= 16'h0000;
    else          baud_cnt <= tick16 ? 16'h0000 : baud_cnt + 16'h0001;
  end

  // ------------------------------------------------------------
  // Receive pin synchroniser
  // ------------------------------------------------------------
  logic [2:0] rx_sync;
  logic       rx_level;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_sync  <= 3'h7;
      rx_level <= 1'b1;
    end else begin
      rx_sync <= {rx_sync[1:0], rx_pin_in};
      if (rx_sync[1] == rx_sync[2]) rx_level <= rx_sync[2];
    end
  end

  // ------------------------------------------------------------
  // Asynchronous transmitter
  // ------------------------------------------------------------
  scp_tx_state_type tx_state;
  logic [3:0]       tx_os;
  logic [2:0]       tx_bit;
  logic [8:0]       tx_sh;
  logic             tx_line;
  logic             tx_set;
  wire              tx_tick = tick16 & (tx_os == OS_LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_state <= TX_IDLE;
      tx_os    <= 4'h0;
      tx_bit   <= 3'h0;
      tx_sh    <= 9'h000;
      tx_line  <= 1'b1;
      tx_set   <= 1'b0;
    end else begin
      tx_set <= 1'b0;
      if (tick16) tx_os <= tx_os + 4'h1;
      case (tx_state)
        TX_IDLE: begin
          tx_os   <= 4'h0;
          tx_line <= 1'b1;
          if (tx_kick && !is_sync) begin
            tx_sh    <= {tb8, pwdata[7:0]};
            tx_line  <= 1'b0;
            tx_state <= TX_START;
          end
        end
        TX_START: if (tx_tick) begin
          tx_bit   <= 3'h0;
          tx_line  <= tx_sh[0];
          tx_state <= TX_DATA;
        end
        TX_DATA: if (tx_tick) begin
          tx_sh  <= tx_sh >> 1;
          tx_bit <= tx_bit + 3'h1;
          if (tx_bit == 3'h7) begin
            tx_line  <= nine ? tx_sh[1] : 1'b1;
            tx_set   <= ~nine;
            tx_state <= nine ? TX_NINTH : TX_STOP;
          end else begin
            tx_line <= tx_sh[1];
          end
        end
        TX_NINTH: if (tx_tick) begin
          tx_line  <= 1'b1;
          tx_set   <= 1'b1;
          tx_state <= TX_STOP;
        end
        TX_STOP: if (tx_tick) tx_state <= TX_IDLE;
        default: tx_state <= TX_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Synchronous shifter, master of the shift clock
  // ------------------------------------------------------------
  logic       m0_busy;
  logic       m0_rx;
  logic [3:0] m0_cnt;
  logic [2:0] m0_bit;
  logic [7:0] m0_sh;
  logic       m0_smp;
  logic       m0_clk;
  logic       m0_tx_set;
  logic       m0_rx_set;
  wire        m0_wrap     = m0_cnt == M0_LAST;
  wire        m0_go_tx    = is_sync & ~m0_busy & tx_kick;
  // A byte still on its way to the flag blocks a restart for one cycle
  wire        m0_go_rx    = is_sync & ~m0_busy & ~tx_kick & ren & ~ri & ~m0_rx_set;
  wire        m0_end      = m0_busy & m0_wrap & (m0_bit == 3'h7);
  wire [7:0]  m0_rx_byte  = {m0_smp, m0_sh[7:1]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      m0_busy   <= 1'b0;
      m0_rx     <= 1'b0;
      m0_cnt    <= 4'h0;
      m0_bit    <= 3'h0;
      m0_sh     <= 8'h00;
      m0_smp    <= 1'b1;
      m0_clk    <= 1'b1;
      rx_pin_oe <= 1'b0;
      m0_tx_set <= 1'b0;
      m0_rx_set <= 1'b0;
    end else begin
      m0_tx_set <= m0_end & ~m0_rx;
      m0_rx_set <= m0_end & m0_rx;
      if (m0_go_tx || m0_go_rx) begin
        m0_busy   <= 1'b1;
        m0_rx     <= m0_go_rx;
        m0_cnt    <= 4'h0;
        m0_bit    <= 3'h0;
        m0_sh     <= m0_go_tx ? pwdata[7:0] : 8'h00;
        m0_clk    <= 1'b0;
        rx_pin_oe <= m0_go_tx & ~pwdata[0];
      end else if (m0_busy) begin
        m0_cnt <= m0_wrap ? 4'h0 : m0_cnt + 4'h1;
        // Low for six cycles then high for six: twelve per bit
        m0_clk <= m0_wrap ? m0_end : (m0_cnt >= M0_HALF - 4'h1);
        if (m0_cnt == M0_HALF) m0_smp <= rx_level;
        if (m0_wrap) begin
          m0_sh     <= m0_rx ? m0_rx_byte : m0_sh >> 1;
          m0_bit    <= m0_bit + 3'h1;
          rx_pin_oe <= ~m0_rx & ~m0_end & ~m0_sh[1];
          if (m0_end) m0_busy <= 1'b0;
        end
      end
    end
  end

  assign tx_pin_out = is_sync ? m0_clk : tx_line;

  // ------------------------------------------------------------
  // Asynchronous receiver and load decision
  // ------------------------------------------------------------
  wire       rx_done;
  wire [7:0] rx_data;
  wire       rx_ninth;
  wire       rx_stop;

  scp_rx u_rx (
    .pclk      (pclk),
    .presetn   (presetn),
    .tick      (tick16),
    .enable    (ren & ~is_sync),
    .nine_bits (nine),
    .line      (rx_level),
    .done      (rx_done),
    .data      (rx_data),
    .ninth     (rx_ninth),
    .stop_bit  (rx_stop)
  );

  wire addr_hit = ((rx_data ^ own_addr) & addr_mask) == 8'h00;
  wire mp_ok    = ~mp_en | (nine ? (rx_ninth & addr_hit) : rx_stop);
  wire as_load  = rx_done & mp_ok & ~ri;
  wire rx_load  = as_load | m0_rx_set;
  wire rd_data  = rd & hit_data;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_buf    <= 8'h00;
      rb8       <= 1'b0;
      rx_unread <= 1'b0;
    end else begin
      if (as_load) begin
        rx_buf <= rx_data;
        rb8    <= nine ? rx_ninth : rx_stop;
      end else if (m0_rx_set) begin
        rx_buf <= m0_sh;
      end
      rx_unread <= rx_load | (rx_unread & ~rd_data);
    end
  end

  // ------------------------------------------------------------
  // Sticky flags, interrupt
  // ------------------------------------------------------------
  wire [ST_W-1:0] set_vec;
  wire [ST_W-1:0] clr_vec;
  assign set_vec[ST_RX_DONE] = rx_load;
  assign set_vec[ST_TX_DONE] = tx_set | m0_tx_set;
  assign set_vec[ST_OVERRUN] = (rx_done & mp_ok & (ri | rx_unread))
                               | (m0_rx_set & rx_unread);
  assign set_vec[ST_FRAME]   = rx_done & ~rx_stop;
  assign clr_vec = (wr & hit_stat) ? pwdata[ST_W-1:0] :
                   (wr & hit_ctl)  ? {2'b00, pwdata[CTL_TX_DONE:CTL_RX_DONE]} :
                   {ST_W{1'b0}};

  generate
    for (genvar i = 0; i < ST_W; i++) begin : g_flag
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) sticky[i] <= 1'b0;
        else          sticky[i] <= set_vec[i] | (sticky[i] & ~clr_vec[i]);
      end
    end
  endgenerate

  assign irq = |(sticky & irq_mask);

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_tx_done;
    $rose(tx_set) |=> ti;
  endproperty
  a_tx_done: assert property (p_tx_done) else $error("tx done flag not set");

  property p_rx_load;
    as_load |=> ri && rx_buf == $past(rx_data);
  endproperty
  a_rx_load: assert property (p_rx_load) else $error("byte not loaded");

  property p_no_load;
    rx_done && ri |=> rx_buf == $past(rx_buf) && rb8 == $past(rb8);
  endproperty
  a_no_load: assert property (p_no_load) else $error("buffer changed while full");

  property p_overrun;
    rx_done && mp_ok && ri |=> sticky[ST_OVERRUN];
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun missed");

  property p_sticky;
    ri && !(wr && (hit_stat || hit_ctl) && pwdata[0]) |=> ri;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag cleared by hardware");

  property p_irq;
    (ti && irq_mask[ST_TX_DONE]) || (ri && irq_mask[ST_RX_DONE]) |-> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");

  property p_m0_clock;
    is_sync && m0_busy && $fell(m0_clk) |-> (!m0_clk)[*6] ##1 m0_clk[*6];
  endproperty
  a_m0_clock: assert property (p_m0_clock) else $error("shift clock not 1/12");

  property p_tx_start;
    tx_kick && !is_sync && tx_state == TX_IDLE |=> !tx_line ##1 tx_state == TX_START;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("start bit missing");

  property p_read_data;
    setup && !pwrite && hit_data |=> prdata == {24'h000000, $past(rx_buf)};
  endproperty
  a_read_data: assert property (p_read_data) else $error("data read wrong");

  property p_frame;
    rx_done && !rx_stop |=> sticky[ST_FRAME];
  endproperty
  a_frame: assert property (p_frame) else $error("frame error missed");

  c_tx_done: cover property (tx_set);
  c_rx_load: cover property (as_load);
  c_overrun: cover property (set_vec[ST_OVERRUN]);
  c_m0_rx:   cover property (m0_rx_set);

endmodule

// ==== scp_remote_node.sv ====
// Remote serial node: sends async frames, decodes async frames
// Assumes one system clock and a fixed bit length in clock cycles.
`timescale 1ns/1ps
module scp_remote_node #(
  parameter int BIT_CYC = 16
) (
  input  wire logic       pclk,
  input  wire logic       listen,
  input  wire logic       tx_line,
  output      logic       rx_line,
  output      logic [7:0] got,
  output      logic       got_stop,
  output      logic       got_valid
);
  initial begin
    rx_line   = 1'b1;
    got       = 8'h00;
    got_stop  = 1'b0;
    got_valid = 1'b0;
  end
  // Start low, data LSB first, then the given stop level
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge pclk) rx_line <= f[i];
      repeat (BIT_CYC - 1) @(posedge pclk);
    end
    @(posedge pclk) rx_line <= 1'b1;
  endtask
  // Sample each bit at its middle
  initial forever begin
    @(posedge pclk);
    got_valid <= 1'b0;
    if (listen && tx_line === 1'b0) begin
      repeat (BIT_CYC / 2) @(posedge pclk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge pclk);
        got[i] <= tx_line;
      end
      repeat (BIT_CYC) @(posedge pclk);
      got_stop  <= tx_line;
      got_valid <= 1'b1;
    end
  end
endmodule

// ==== scp_tb.sv ====
// Testbench of the serial port core
// Assumes the core's APB map and a remote node at 16 cycles a bit.
`timescale 1ns/1ps
module tb;
  import scp_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, listen;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, rx_pin_out, rx_pin_oe, tx_pin_out, irq;
  logic        node_line, got_stop, got_valid;
  logic [7:0]  got;
  wire         rx_pin_in = (rx_pin_oe ? rx_pin_out : 1'b1) & node_line;
  int          fails, checks;
  logic [32:0] rd_q[$];
  string       nm_q[$];
  logic [7:0]  tx_q[$];
  logic [15:0] seed;
  logic [7:0]  b1, b3;
  int          n;
  logic        clk_d, sync_on;
  logic [7:0]  sync_sh;

  scp_core u_scp_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_pin_in(rx_pin_in), .rx_pin_out(rx_pin_out),
    .rx_pin_oe(rx_pin_oe), .tx_pin_out(tx_pin_out), .irq(irq));
  scp_remote_node #(.BIT_CYC(16)) u_scp_remote_node (.pclk(pclk), .listen(listen),
    .tx_line(tx_pin_out), .rx_line(node_line), .got(got), .got_stop(got_stop),
    .got_valid(got_valid));

  // --------------------------------------------------------------
  // Clock, checking and closing
  // --------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (rd_q.size() == 0) check("unexpected read", 33'h0, 33'h1);
      else check(nm_q.pop_front(), {pslverr, prdata}, rd_q.pop_front());
    end
    if (got_valid) begin
      if (tx_q.size() == 0) check("unexpected frame", 33'h0, 33'h1);
      else check("tx byte", {25'h0, got}, {25'h0, tx_q.pop_front()});
      check("tx stop", {32'h0, got_stop}, 33'h1);
    end
    // Sync mode: take the data pin at each rise of the shift clock
    if (sync_on && tx_pin_out === 1'b1 && clk_d === 1'b0) begin
      sync_sh <= {rx_pin_in, sync_sh[7:1]};
    end
    clk_d <= tx_pin_out;
  end
  initial begin
    repeat (40000) @(posedge pclk);
    fails++;
    tally_and_finish();
  end

  // --------------------------------------------------------------
  // APB master
  // --------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input string name, input logic [7:0] a, input logic [32:0] exp);
    rd_q.push_back(exp);
    nm_q.push_back(name);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic wait_irq(input logic lvl);
    n = 0;
    while (irq !== lvl && n < 1000) begin
      @(posedge pclk);
      n++;
    end
    check("irq", {32'h0, irq}, {32'h0, lvl});
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, listen} = 4'h0;
    paddr  = 8'h00;
    {clk_d, sync_on, sync_sh} = 10'h200;
    pwdata = 32'h0;
    seed   = 16'hde85;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd("control", OFF_CONTROL, 33'h0);
    rd("mask", OFF_MASK, 33'h0);
    rd("baud", OFF_BAUD, 33'h0);
    rd("unmapped", 8'h1c, 33'h100000000);
    apb(1'b1, OFF_MASK, 32'h3);
    apb(1'b1, OFF_CONTROL, 32'h50);
    listen <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      tx_q.push_back(seed[7:0]);
      apb(1'b1, OFF_DATA, {24'h0, seed[7:0]});
      wait_irq(1'b1);
      repeat (24) @(posedge pclk);
      rd("tx flag held", OFF_CONTROL, 33'h52);
      apb(1'b1, OFF_CONTROL, 32'h52);
      apb(1'b1, OFF_STATUS, 32'h2);
      rd("tx flag cleared", OFF_CONTROL, 33'h50);
      wait_irq(1'b0);
    end
    listen <= 1'b0;
    seed = lfsr(seed);
    b1 = seed[7:0];
    u_scp_remote_node.send(b1, 1'b1);
    rd("rx flag", OFF_CONTROL, 33'h55);
    rd("rx status", OFF_STATUS, 33'h1);
    u_scp_remote_node.send(~b1, 1'b1);
    rd("overrun", OFF_STATUS, 33'h5);
    rd("held byte", OFF_DATA, {25'h0, b1});
    apb(1'b1, OFF_CONTROL, 32'h51);
    apb(1'b1, OFF_STATUS, 32'hf);
    seed = lfsr(seed);
    b3 = seed[7:0];
    u_scp_remote_node.send(b3, 1'b1);
    rd("next byte", OFF_DATA, {25'h0, b3});
    rd("no overrun", OFF_STATUS, 33'h1);
    apb(1'b1, OFF_CONTROL, 32'h71);
    apb(1'b1, OFF_STATUS, 32'hf);
    u_scp_remote_node.send(~b3, 1'b0);
    rd("bad stop refused", OFF_CONTROL, 33'h74);
    rd("frame error", OFF_STATUS, 33'h8);
    apb(1'b1, OFF_STATUS, 32'hf);
    apb(1'b1, OFF_ADDR, 32'h3c);
    apb(1'b1, OFF_AMASK, 32'hff);
    apb(1'b1, OFF_CONTROL, 32'hf8);
    listen <= 1'b1;
    tx_q.push_back(8'h5a);
    apb(1'b1, OFF_DATA, 32'h5a);
    wait_irq(1'b1);
    repeat (24) @(posedge pclk);
    listen <= 1'b0;
    apb(1'b1, OFF_CONTROL, 32'hfa);
    // Wrong address, then a data frame, then the matching address frame
    for (int i = 0; i < 3; i++) begin
      u_scp_remote_node.send((i == 0) ? 8'h3d : 8'h3c, i != 1);
      repeat (20) @(posedge pclk);
    end
    rd("address match", OFF_CONTROL, 33'hfd);
    rd("mp status", OFF_STATUS, 33'h1);
    rd("address byte", OFF_DATA, 33'h3c);
    apb(1'b1, OFF_STATUS, 32'hf);
    apb(1'b1, OFF_CONTROL, 32'h00);
    sync_on <= 1'b1;
    apb(1'b1, OFF_DATA, 32'ha5);
    n = 0;
    while (tx_pin_out !== 1'b0 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    n = 0;
    while (tx_pin_out === 1'b0 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    check("shift clock low", 33'(n), 33'd6);
    n = 0;
    while (tx_pin_out === 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    check("shift clock high", 33'(n), 33'd6);
    wait_irq(1'b1);
    rd("sync tx flag", OFF_CONTROL, 33'h06);
    check("sync tx data", {25'h0, sync_sh}, 33'ha5);
    apb(1'b1, OFF_CONTROL, 32'h13);
    wait_irq(1'b0);
    wait_irq(1'b1);
    repeat (120) @(posedge pclk);
    rd("sync rx once", OFF_STATUS, 33'h1);
    rd("sync rx byte", OFF_DATA, 33'hff);
    repeat (4) @(posedge pclk);
    tally_and_finish();
  end
endmodule
